// ### core/spfd_pkg.sv
package spfd_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_TX_PORT = 8'h08;
  localparam logic [7:0] OFS_RX_PORT = 8'h0c;
  localparam logic [7:0] OFS_BCOUNT  = 8'h10;
  localparam logic [7:0] OFS_MASK    = 8'h14;
  // ==========================================
  // Control fields
  localparam int CTL_WORD_WIDTH = 30;
  localparam int CTL_TIE = 9;
  localparam int CTL_RIE = 8;
  localparam int CTL_DIR = 0;
  // ==========================================
  // Status fields
  localparam int ST_TXOV = 11;
  localparam int ST_RXOV = 9;
  localparam int ST_RXUN = 8;
  localparam int ST_RXFU = 7;
  localparam int ST_RXEM = 6;
  localparam int ST_TXFU = 5;
  localparam int ST_TXEM = 4;
  localparam int ST_TPD  = 3;
  localparam int ST_RPD  = 2;
  localparam int ST_BUSY = 0;
  localparam logic [11:0] STICKY_BITS = 12'hb0c;
  // ==========================================
  // Reset values and sizes
  localparam logic [1:0]  DIR_RESET  = 2'h0;
  localparam logic [11:0] MASK_RESET = 12'h000;
  localparam logic [12:0] BC_RESET   = 13'h0000;
  localparam int BC_W = 13;
  localparam int TX_IRQ_FREE = 2;
  typedef enum logic [1:0] {
    SPFD_DIR_OFF, SPFD_DIR_READ, SPFD_DIR_WRITE, SPFD_DIR_BOTH
  } spfd_dir_e;
endpackage

// ### core/spfd_top.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module spfd_top import spfd_pkg::*; #(
  parameter int DEPTH_BYTES = 16,
  parameter int DEPTH_WORDS = 4
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        sclk_in,
  input  wire logic        ss_b_in,
  input  wire logic        mosi_in,
  output logic             miso_out,
  output logic             irq_out
);
  // Storage and pointers are sized for these depths only
  if (DEPTH_BYTES != 16 || DEPTH_WORDS != 4) begin : g_depth_check
    $error("fifo depths must be 16 bytes and 4 words");
  end

  // ==========================================
  // State
  logic              fifo_word_width, tie, rie;
  spfd_dir_e         dir;
  logic [11:0]       mask, sticky;
  logic [BC_W-1:0]   bc, remain;
  logic [31:0]       txm [16];
  logic [31:0]       rxm [16];
  logic [3:0]        tx_wp, tx_rp, rx_wp, rx_rp;
  logic [4:0]        tx_cnt, rx_cnt, bitc;
  logic [31:0]       sh_rx, sh_tx;
  logic              ldpend, miso, pready, pslverr, irq;
  logic [31:0]       prdata;
  logic              sclk_s1, sclk_s2, sclk_s3;
  logic              ss_s1, ss_s2, ss_s3, mosi_s1, mosi_s2;

  logic              next_fifo_word_width, next_tie, next_rie;
  spfd_dir_e         next_dir;
  logic [11:0]       next_mask, next_sticky;
  logic [BC_W-1:0]   next_bc, next_remain;
  logic [31:0]       next_txm [16];
  logic [31:0]       next_rxm [16];
  logic [3:0]        next_tx_wp, next_tx_rp, next_rx_wp, next_rx_rp;
  logic [4:0]        next_tx_cnt, next_rx_cnt, next_bitc;
  logic [31:0]       next_sh_rx, next_sh_tx, next_prdata;
  logic              next_ldpend, next_miso, next_pready, next_pslverr, next_irq;

  logic              acc, wr, rd, active, rise, fall, start, unit_last;
  logic              tx_push, tx_pop, rx_push, rx_pop, rx_try;
  logic [4:0]        lim;
  logic [31:0]       stat;

  // Byte mode keeps only bits 7:0
  function automatic logic [31:0] width_mask(input logic w, input logic [31:0] d);
    width_mask = w ? d : {24'h000000, d[7:0]};
  endfunction

  // ==========================================
  // Pin synchronisers
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      ss_s1   <= 1'b1;
      ss_s2   <= 1'b1;
      ss_s3   <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= sclk_in;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      ss_s1   <= ss_b_in;
      ss_s2   <= ss_s1;
      ss_s3   <= ss_s2;
      mosi_s1 <= mosi_in;
      mosi_s2 <= mosi_s1;
    end
  end

  // ==========================================
  // Next-state logic
  always_comb begin
    next_fifo_word_width = fifo_word_width;
    next_tie = tie;
    next_rie = rie;
    next_dir = dir;
    next_mask = mask;
    next_sticky = sticky;
    next_bc = bc;
    next_remain = remain;
    next_txm = txm;
    next_rxm = rxm;
    next_tx_wp = tx_wp;
    next_tx_rp = tx_rp;
    next_rx_wp = rx_wp;
    next_rx_rp = rx_rp;
    next_bitc = bitc;
    next_sh_rx = sh_rx;
    next_sh_tx = sh_tx;
    next_ldpend = ldpend;
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_try = 1'b0;
    lim = fifo_word_width ? 5'(DEPTH_WORDS) : 5'(DEPTH_BYTES);
    acc = psel_in & penable_in & ~pready;
    wr = acc & pwrite_in;
    rd = acc & ~pwrite_in;
    // Slave selected but not clocking still counts as busy
    active = ~ss_s2;
    start = ss_s3 & ~ss_s2;
    rise = active & ~sclk_s3 & sclk_s2;
    fall = active & sclk_s3 & ~sclk_s2;
    unit_last = bitc == (fifo_word_width ? 5'h1f : 5'h07);
    stat = 32'h00000000;
    stat[11:0] = sticky & STICKY_BITS;
    stat[ST_RXFU] = rx_cnt == lim;
    stat[ST_RXEM] = rx_cnt == 5'h00;
    stat[ST_TXFU] = tx_cnt == lim;
    stat[ST_TXEM] = tx_cnt == 5'h00;
    stat[ST_BUSY] = active | (remain != '0);
    next_pready = acc;

    // Register access, committed on the same edge that raises pready
    if (acc) begin
      unique case (paddr_in)
        OFS_CONTROL: begin
          if (wr) begin
            next_fifo_word_width = pwdata_in[CTL_WORD_WIDTH];
            next_tie = pwdata_in[CTL_TIE];
            next_rie = pwdata_in[CTL_RIE];
            next_dir = spfd_dir_e'(pwdata_in[CTL_DIR +: 2]);
          end
          next_prdata[CTL_WORD_WIDTH] = fifo_word_width;
          next_prdata[CTL_TIE] = tie;
          next_prdata[CTL_RIE] = rie;
          next_prdata[CTL_DIR +: 2] = dir;
        end
        OFS_STATUS: begin
          if (wr)
            next_sticky = sticky & ~pwdata_in[11:0];
          next_prdata = stat;
        end
        OFS_TX_PORT: begin
          if (wr) begin
            if (tx_cnt == lim)
              next_sticky[ST_TXOV] = 1'b1;
            else
              tx_push = 1'b1;
          end
        end
        OFS_RX_PORT: begin
          if (rd) begin
            if (rx_cnt == 5'h00)
              next_sticky[ST_RXUN] = 1'b1;
            else begin
              rx_pop = 1'b1;
              next_prdata = width_mask(fifo_word_width, rxm[rx_rp]);
            end
          end
        end
        OFS_BCOUNT: begin
          if (wr) begin
            next_bc = pwdata_in[BC_W-1:0];
            next_remain = pwdata_in[BC_W-1:0];
          end
          next_prdata[BC_W-1:0] = bc;
        end
        OFS_MASK: begin
          if (wr)
            next_mask = pwdata_in[11:0];
          next_prdata[11:0] = mask;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
    if (tx_push) begin
      next_txm[tx_wp] = width_mask(fifo_word_width, pwdata_in);
      next_tx_wp = tx_wp + 4'h1;
    end

    // ==========================================
    // Link shifter, mode 0, MSB first
    if (start) begin
      next_bitc = 5'h00;
      next_ldpend = 1'b1;
    end else if (rise) begin
      next_sh_rx = {sh_rx[30:0], mosi_s2};
      next_bitc = unit_last ? 5'h00 : bitc + 5'h01;
      next_ldpend = unit_last;
      if (unit_last && dir[0])
        rx_try = (dir != SPFD_DIR_READ) || (remain != '0);
    end
    // Loading on the edge that would shift puts bit 7 (byte mode) or bit 31 (word mode) on the pin
    if ((start | (fall & ldpend)) && dir[1]) begin
      next_ldpend = 1'b0;
      if (tx_cnt != 5'h00) begin
        tx_pop = 1'b1;
        next_sh_tx = txm[tx_rp];
      end else
        next_sh_tx = 32'h00000000;
    end else if (fall) begin
      next_sh_tx = {sh_tx[30:0], 1'b0};
      next_ldpend = 1'b0;
    end
    if (tx_pop)
      next_tx_rp = tx_rp + 4'h1;
    next_miso = fifo_word_width ? next_sh_tx[31] : next_sh_tx[7];

    if (rx_try) begin
      if (dir == SPFD_DIR_READ)
        next_remain = (!fifo_word_width || remain < 13'h0004) ? remain - 13'h0001 : remain - 13'h0004;
      if (rx_cnt == lim)
        next_sticky[ST_RXOV] = 1'b1;
      else
        rx_push = 1'b1;
    end
    if (rx_push) begin
      next_rxm[rx_wp] = width_mask(fifo_word_width, next_sh_rx);
      next_rx_wp = rx_wp + 4'h1;
    end
    if (rx_pop)
      next_rx_rp = rx_rp + 4'h1;
    next_tx_cnt = tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
    next_rx_cnt = rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};

    // two free tx levels raise pending
    if (tie && (lim - tx_cnt) >= 5'(TX_IRQ_FREE))
      next_sticky[ST_TPD] = 1'b1;
    if (rie && rx_cnt != 5'h00)
      next_sticky[ST_RPD] = 1'b1;
    // New mask takes effect with the write, like the status bits
    next_irq = |(next_sticky & STICKY_BITS & next_mask);
  end

  // ==========================================
  // Registers
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fifo_word_width <= 1'b0;
      tie     <= 1'b0;
      rie     <= 1'b0;
      dir     <= spfd_dir_e'(DIR_RESET);
      mask    <= MASK_RESET;
      sticky  <= 12'h000;
      bc      <= BC_RESET;
      remain  <= BC_RESET;
      for (int i = 0; i < 16; i++) begin
        txm[i] <= 32'h00000000;
        rxm[i] <= 32'h00000000;
      end
      tx_wp   <= 4'h0;
      tx_rp   <= 4'h0;
      rx_wp   <= 4'h0;
      rx_rp   <= 4'h0;
      tx_cnt  <= 5'h00;
      rx_cnt  <= 5'h00;
      bitc    <= 5'h00;
      sh_rx   <= 32'h00000000;
      sh_tx   <= 32'h00000000;
      ldpend  <= 1'b0;
      miso    <= 1'b0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      irq     <= 1'b0;
    end else begin
      fifo_word_width <= next_fifo_word_width;
      tie     <= next_tie;
      rie     <= next_rie;
      dir     <= next_dir;
      mask    <= next_mask;
      sticky  <= next_sticky;
      bc      <= next_bc;
      remain  <= next_remain;
      txm     <= next_txm;
      rxm     <= next_rxm;
      tx_wp   <= next_tx_wp;
      tx_rp   <= next_tx_rp;
      rx_wp   <= next_rx_wp;
      rx_rp   <= next_rx_rp;
      tx_cnt  <= next_tx_cnt;
      rx_cnt  <= next_rx_cnt;
      bitc    <= next_bitc;
      sh_rx   <= next_sh_rx;
      sh_tx   <= next_sh_tx;
      ldpend  <= next_ldpend;
      miso    <= next_miso;
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
      irq     <= next_irq;
    end
  end

  assign prdata_out  = prdata;
  assign pready_out  = pready;
  assign pslverr_out = pslverr;
  assign miso_out    = miso;
  assign irq_out     = irq;

  // ==========================================
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_tx_overflow: assert property (wr && paddr_in == OFS_TX_PORT && tx_cnt == lim |=> sticky[ST_TXOV])
    else $error("tx overflow not flagged");
  a_rx_overflow: assert property (rx_try && rx_cnt == lim |=> sticky[ST_RXOV] && rx_cnt == $past(rx_cnt) - {4'h0, $past(rx_pop)})
    else $error("rx overflow not flagged");
  a_rx_underrun: assert property (rd && paddr_in == OFS_RX_PORT && rx_cnt == 5'h00 |=> sticky[ST_RXUN] && prdata_out == 32'h00000000)
    else $error("rx underrun not flagged");
  a_rx_flags: assert property (rx_cnt == 5'h00 |-> stat[ST_RXEM] && !stat[ST_RXFU])
    else $error("rx flags wrong");
  a_tx_flags: assert property (tx_cnt == lim |-> stat[ST_TXFU] && !stat[ST_TXEM])
    else $error("tx flags wrong");
  a_tpd_hold: assert property (sticky[ST_TPD] && !(wr && paddr_in == OFS_STATUS && pwdata_in[ST_TPD]) |=> sticky[ST_TPD])
    else $error("tx pending lost");
  a_rpd_hold: assert property (sticky[ST_RPD] && !(wr && paddr_in == OFS_STATUS && pwdata_in[ST_RPD]) |=> sticky[ST_RPD])
    else $error("rx pending lost");
  a_busy_count: assert property (remain != '0 |-> stat[ST_BUSY])
    else $error("busy low while counting");
  a_rx_pop: assert property (rd && paddr_in == OFS_RX_PORT && rx_cnt != 5'h00 && !rx_push |=> rx_cnt == $past(rx_cnt) - 5'h01)
    else $error("rx read did not pop");
  a_bc_load: assert property (wr && paddr_in == OFS_BCOUNT |=> bc == $past(pwdata_in[12:0]))
    else $error("byte count not loaded");
  a_tirq_raise: assert property (tie && (lim - tx_cnt) >= 5'h02 |=> sticky[ST_TPD])
    else $error("tx pending not raised");
  a_apb_answer: assert property (acc |=> pready_out ##1 !pready_out)
    else $error("apb answer timing wrong");

  c_tx_overflow: cover property (wr && paddr_in == OFS_TX_PORT && tx_cnt == lim);
  c_rx_push: cover property (rx_push ##[1:200] rd && paddr_in == OFS_RX_PORT);
  c_irq_rise: cover property (!irq_out ##1 irq_out);
endmodule

// ### test/spfd_peer.sv
`timescale 1ns/1ps
module spfd_peer (
  input  wire logic miso_in,
  output logic      sclk_out,
  output logic      ss_b_out,
  output logic      mosi_out
);
  initial begin
    sclk_out <= 1'b0;
    ss_b_out <= 1'b1;
    mosi_out <= 1'b0;
  end
  // ========================================
  // Frame tasks, mode 0, MSB first
  // Clock idles low; lead-in covers the select synchroniser
  task automatic start();
    ss_b_out <= 1'b0;
    #80;
  endtask
  task automatic unit(input int nb, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    for (int i = nb - 1; i >= 0; i--) begin
      mosi_out <= tx[i];
      #40;
      sclk_out <= 1'b1;
      rx = {rx[30:0], miso_in};
      #80;
      sclk_out <= 1'b0;
      #40;
    end
  endtask
  // Released data line toggles so a stale bit is never read
  task automatic stop();
    ss_b_out <= 1'b1;
    mosi_out <= ~mosi_out;
    #160;
  endtask
endmodule

// ### test/spfd_top_tb.sv
`timescale 1ns/1ps
module spfd_top_tb import spfd_pkg::*;;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, sclk, ss_b, mosi, miso, perr;
  logic        m_txov, m_rxov, m_rxun, m_tpd, m_rpd, m_busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv, d;
  logic [31:0] txq[$], rxq[$];
  int          num_errors, total_checks, dep;

  spfd_top u_dut (.ref_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .sclk_in(sclk), .ss_b_in(ss_b),
    .mosi_in(mosi), .miso_out(miso), .irq_out(irq));
  spfd_peer u_peer (.miso_in(miso), .sclk_out(sclk), .ss_b_out(ss_b), .mosi_out(mosi));

  // ========================================
  // Checking and bus tasks
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] mstat();
    return {20'h0, m_txov, 1'b0, m_rxov, m_rxun, rxq.size() == dep, rxq.size() == 0,
            txq.size() == dep, txq.size() == 0, m_tpd, m_rpd, 1'b0, m_busy};
  endfunction
  // Reserved bits 31:12, 10 and 1 are not compared
  task automatic st();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", mstat(), rv & 32'h00000bfd);
    chk("status err", 32'h0, {31'h0, perr});
  endtask
  task automatic push_tx(input int n, input logic [31:0] wm);
    for (int k = 0; k < n; k++) begin
      d = $urandom() & wm;
      apb(1'b1, OFS_TX_PORT, d);
      if (txq.size() < dep) txq.push_back(d);
      else m_txov = 1'b1;
    end
  endtask
  task automatic frame(input int n, input int nb, input logic snd, input int ns);
    logic [31:0] r, e;
    u_peer.start();
    for (int k = 0; k < n; k++) begin
      d = $urandom() & ((nb == 32) ? 32'hffffffff : 32'h000000ff);
      e = (snd && txq.size() > 0) ? txq.pop_front() : 32'h0;
      u_peer.unit(nb, d, r);
      if (snd) chk("miso unit", e, r);
      if (k < ns && rxq.size() == dep) m_rxov = 1'b1;
      else if (k < ns) rxq.push_back(d);
    end
    u_peer.stop();
  endtask
  task automatic drain();
    while (rxq.size() > 0) begin
      apb(1'b0, OFS_RX_PORT, 32'h0);
      chk("rx word", rxq.pop_front(), rv);
    end
  endtask

  // ========================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    total_checks = 0;
    dep = 16;
    {m_txov, m_rxov, m_rxun, m_tpd, m_rpd, m_busy} = 6'h00;
    void'($urandom(68));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    st();
    apb(1'b0, OFS_BCOUNT, 32'h0);
    chk("byte count", 32'h0, rv);
    apb(1'b0, OFS_TX_PORT, 32'h0);
    chk("tx port read", 32'h0, rv);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, perr});
    // Underrun on empty read, write-one clear
    apb(1'b0, OFS_RX_PORT, 32'h0);
    chk("empty rx read", 32'h0, rv);
    m_rxun = 1'b1;
    apb(1'b1, OFS_STATUS, 32'h0);
    st();
    apb(1'b1, OFS_STATUS, 32'h00000100);
    m_rxun = 1'b0;
    st();
    // Byte mode, both directions, both fifos overrun
    apb(1'b1, OFS_CONTROL, 32'h00000003);
    push_tx(17, 32'h000000ff);
    st();
    frame(17, 8, 1'b1, 1000);
    st();
    drain();
    apb(1'b1, OFS_STATUS, 32'h00000a00);
    {m_txov, m_rxov} = 2'b00;
    st();
    // Word mode fill to full
    apb(1'b1, OFS_CONTROL, 32'h40000003);
    dep = 4;
    push_tx(4, 32'hffffffff);
    st();
    frame(4, 32, 1'b1, 1000);
    st();
    drain();
    // Read-only mode bounded by the byte count
    apb(1'b1, OFS_CONTROL, 32'h00000001);
    dep = 16;
    apb(1'b1, OFS_BCOUNT, 32'h00000003);
    apb(1'b0, OFS_BCOUNT, 32'h0);
    chk("byte count", 32'h3, rv);
    m_busy = 1'b1;
    st();
    frame(4, 8, 1'b0, 3);
    m_busy = 1'b0;
    st();
    drain();
    // Disabled and write-only store nothing
    for (int k = 0; k < 3; k += 2) begin
      apb(1'b1, OFS_CONTROL, k);
      frame(1, 8, k[1], 0);
      st();
    end
    // Interrupt raise, mask and clear
    apb(1'b1, OFS_MASK, 32'h0000000c);
    apb(1'b0, OFS_MASK, 32'h0);
    chk("mask", 32'h0000000c, rv);
    apb(1'b1, OFS_CONTROL, 32'h00000303);
    apb(1'b0, OFS_CONTROL, 32'h0);
    chk("control", 32'h00000303, rv);
    m_tpd = 1'b1;
    st();
    chk("irq", 32'h1, {31'h0, irq});
    frame(1, 8, 1'b1, 1000);
    m_rpd = 1'b1;
    st();
    apb(1'b1, OFS_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_CONTROL, 32'h00000003);
    apb(1'b1, OFS_STATUS, 32'h0);
    st();
    apb(1'b1, OFS_STATUS, 32'h0000000c);
    {m_tpd, m_rpd} = 2'b00;
    st();
    apb(1'b1, OFS_MASK, 32'h0000000c);
    chk("irq cleared", 32'h0, {31'h0, irq});
    drain();
    finish_test();
  end
endmodule
